/* logic/apar_params.svh */
// Constants for the audio port and activity register bank
`ifndef APAR_PARAMS_SVH
`define APAR_PARAMS_SVH
// Byte addresses are four times the printed register index
`define APAR_IDX_PORT_CFG      8'h09
`define APAR_IDX_OFF_LOW       8'h0b
`define APAR_IDX_OFF_HIGH      8'h0c
`define APAR_IDX_ON_TIME       8'h0d
`define APAR_IDX_ADC_REF       8'h0e
`define APAR_IDX_DAC_REF       8'h0f
`define APAR_IDX_STATUS        8'h10
`define APAR_BIT_LOOPBACK      7
`define APAR_BIT_RX_SLOT       6
`define APAR_BIT_RESERVED      5
`define APAR_BIT_MASTER        4
`define APAR_BIT_FLOAT_EN      3
`define APAR_BIT_TX_FIRST      2
`define APAR_BIT_TX_SECOND     1
`define APAR_BIT_PROTOCOL      0
`define APAR_CFG_RESET_BASE    8'h24
`define APAR_BYTE_RESET        8'h00
`define APAR_SLOT_BITS         16
`endif

/* logic/apar_pkg.sv */
// Types shared by the audio port and activity register bank
package apar_pkg;
    typedef enum logic [1:0] {
        APAR_SLOT_IDLE,
        APAR_SLOT_FIRST,
        APAR_SLOT_SECOND
    } apar_slot_e;
    typedef logic [7:0] apar_byte_t;
endpackage

/* logic/apar_regs.sv */
// Audio port configuration and activity detector register bank with APB slave
//
// Implementation choice: the APB register port.
`timescale 1ns/1ns
`include "apar_params.svh"
module apar_regs (
    input  wire logic                 clk_in,
    input  wire logic                 reset_n_in,
    input  wire logic                 clk_en_in,
    input  wire logic                 bit_clock_strap_in,
    input  wire logic                 psel_in,
    input  wire logic                 penable_in,
    input  wire logic                 pwrite_in,
    input  wire logic [7:0]           paddr_in,
    input  wire logic [31:0]          pwdata_in,
    output logic                      pready_out,
    output logic                      pslverr_out,
    output logic [31:0]               prdata_out,
    input  wire logic                 link_clk_in,
    input  wire logic                 frame_sync_in,
    input  wire logic                 link_rx_data_in,
    input  wire logic [15:0]          adc_sample_in,
    output logic [15:0]               dac_sample_out,
    output logic                      dac_sample_valid_out,
    output logic                      serial_audio_out,
    output logic                      serial_audio_oe_n_out,
    output logic                      frame_sync_out,
    output logic                      frame_sync_oe_n_out,
    output logic                      loopback_out,
    output logic                      master_role_out,
    output logic                      short_frame_sync_out,
    output logic [15:0]               activity_off_time_out,
    output apar_pkg::apar_byte_t      activity_on_time_out,
    output apar_pkg::apar_byte_t      adc_activity_reference_out,
    output apar_pkg::apar_byte_t      dac_activity_reference_out
);
    import apar_pkg::*;

    // ************************************************************
    // Reset and strap capture
    // ************************************************************
    logic       rst_meta_reg;
    logic       rst_sync_reg;
    logic       strap_meta_reg;
    logic       strap_sync_reg;
    logic       strap_done_reg;
    wire  logic rst_n;
    assign rst_n = rst_sync_reg;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // Strap flops leave reset two edges before the rest, so the capture sees the pin
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            strap_meta_reg <= 1'b0;
            strap_sync_reg <= 1'b0;
        end else if (clk_en_in) begin
            strap_meta_reg <= bit_clock_strap_in;
            strap_sync_reg <= strap_meta_reg;
        end
    end

    // ************************************************************
    // APB decode
    // ************************************************************
    apar_byte_t port_cfg_reg;
    apar_byte_t off_low_reg;
    apar_byte_t off_high_reg;
    apar_byte_t on_time_reg;
    apar_byte_t adc_ref_reg;
    apar_byte_t dac_ref_reg;
    logic       rx_slot_seen_reg;

    wire logic [5:0] word_idx;
    wire logic       aligned;
    wire logic       access;
    wire logic       wr;
    wire logic       hit_cfg;
    wire logic       hit_offl;
    wire logic       hit_offh;
    wire logic       hit_on;
    wire logic       hit_adc;
    wire logic       hit_dac;
    wire logic       hit_stat;
    wire logic       mapped;
    wire logic [7:0] rd_byte;
    wire logic [7:0] cfg_wr_value;
    wire logic       want_short;
    wire logic       want_master;

    assign word_idx = paddr_in[7:2];
    assign aligned  = (paddr_in[1:0] == 2'h0);
    assign access   = psel_in && penable_in && clk_en_in;
    assign hit_cfg  = aligned && ({2'h0, word_idx} == `APAR_IDX_PORT_CFG);
    assign hit_offl = aligned && ({2'h0, word_idx} == `APAR_IDX_OFF_LOW);
    assign hit_offh = aligned && ({2'h0, word_idx} == `APAR_IDX_OFF_HIGH);
    assign hit_on   = aligned && ({2'h0, word_idx} == `APAR_IDX_ON_TIME);
    assign hit_adc  = aligned && ({2'h0, word_idx} == `APAR_IDX_ADC_REF);
    assign hit_dac  = aligned && ({2'h0, word_idx} == `APAR_IDX_DAC_REF);
    assign hit_stat = aligned && ({2'h0, word_idx} == `APAR_IDX_STATUS);
    assign mapped   = hit_cfg | hit_offl | hit_offh | hit_on | hit_adc | hit_dac | hit_stat;
    assign wr       = access && pwrite_in && !pready_out;

    // Master needs long framing: a write asking both keeps slave role
    assign want_short   = pwdata_in[`APAR_BIT_PROTOCOL];
    assign want_master  = pwdata_in[`APAR_BIT_MASTER] && !want_short;
    assign cfg_wr_value = {pwdata_in[7:6], 1'b1, want_master, pwdata_in[3:1], want_short};

    assign rd_byte = hit_cfg  ? port_cfg_reg :
                     hit_offl ? off_low_reg  :
                     hit_offh ? off_high_reg :
                     hit_on   ? on_time_reg  :
                     hit_adc  ? adc_ref_reg  :
                     hit_dac  ? dac_ref_reg  :
                     hit_stat ? {7'h00, rx_slot_seen_reg} : 8'h00;

    // ************************************************************
    // Registers and APB answer
    // ************************************************************
    // One-wait answer: pready rises in the second access cycle
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0;
        end else if (clk_en_in) begin
            pready_out  <= access && !pready_out;
            pslverr_out <= access && !pready_out && !mapped;
            prdata_out  <= (access && !pready_out && !pwrite_in) ? {24'h0, rd_byte} : 32'h0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            port_cfg_reg   <= `APAR_CFG_RESET_BASE;
            strap_done_reg <= 1'b0;
        end else if (clk_en_in) begin
            if (!strap_done_reg) begin
                strap_done_reg <= 1'b1;
                port_cfg_reg[`APAR_BIT_PROTOCOL] <= !strap_sync_reg;
            end else if (wr && hit_cfg) begin
                port_cfg_reg <= cfg_wr_value;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            off_low_reg  <= `APAR_BYTE_RESET;
            off_high_reg <= `APAR_BYTE_RESET;
            on_time_reg  <= `APAR_BYTE_RESET;
            adc_ref_reg  <= `APAR_BYTE_RESET;
            dac_ref_reg  <= `APAR_BYTE_RESET;
        end else if (clk_en_in && wr) begin
            if (hit_offl) off_low_reg  <= pwdata_in[7:0];
            if (hit_offh) off_high_reg <= pwdata_in[7:0];
            if (hit_on)   on_time_reg  <= pwdata_in[7:0];
            if (hit_adc)  adc_ref_reg  <= pwdata_in[7:0];
            if (hit_dac)  dac_ref_reg  <= pwdata_in[7:0];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            loopback_out               <= 1'b0;
            master_role_out            <= 1'b0;
            short_frame_sync_out       <= 1'b0;
            activity_off_time_out      <= 16'h0;
            activity_on_time_out       <= 8'h00;
            adc_activity_reference_out <= 8'h00;
            dac_activity_reference_out <= 8'h00;
        end else if (clk_en_in) begin
            loopback_out               <= port_cfg_reg[`APAR_BIT_LOOPBACK];
            master_role_out            <= port_cfg_reg[`APAR_BIT_MASTER];
            short_frame_sync_out       <= port_cfg_reg[`APAR_BIT_PROTOCOL];
            activity_off_time_out      <= {off_high_reg, off_low_reg};
            activity_on_time_out       <= on_time_reg;
            adc_activity_reference_out <= adc_ref_reg;
            dac_activity_reference_out <= dac_ref_reg;
        end
    end

    // ************************************************************
    // Link domain
    // ************************************************************
    // Config bits are quasi-static; each crosses on its own two flops
    logic [7:0]  cfg_meta_reg;
    logic [7:0]  cfg_link_reg;
    logic        req_meta_reg;
    logic        req_sync_reg;
    logic        adc_ack_reg;
    logic [15:0] adc_link_reg;
    logic [15:0] adc_hold_reg;
    logic        adc_req_reg;
    logic        ack_meta_reg;
    logic        ack_sync_reg;
    logic        lrst_meta_reg;
    logic        lrst_reg;
    logic        fs_d_reg;
    logic [4:0]  bit_cnt_reg;
    apar_slot_e  slot_reg;
    logic [15:0] tx_shift_reg;
    logic [15:0] rx_shift_reg;
    logic        rx_toggle_reg;
    logic [15:0] rx_word_reg;
    logic [4:0]  mfs_cnt_reg;

    wire logic fs_rise;
    wire logic fs_src;
    wire logic tx_slot_en;
    wire logic rx_slot_hit;
    wire logic slot_last;
    wire logic adc_free;
    assign fs_src     = cfg_link_reg[`APAR_BIT_MASTER] ? (mfs_cnt_reg == 5'h0) : frame_sync_in;
    assign fs_rise    = fs_src && !fs_d_reg;
    assign slot_last  = (bit_cnt_reg == 5'(`APAR_SLOT_BITS - 1));
    assign tx_slot_en = (slot_reg == APAR_SLOT_FIRST)  ? cfg_link_reg[`APAR_BIT_TX_FIRST] :
                        (slot_reg == APAR_SLOT_SECOND) ? cfg_link_reg[`APAR_BIT_TX_SECOND] :
                        1'b0;
    assign rx_slot_hit = (slot_reg == (cfg_link_reg[`APAR_BIT_RX_SLOT] ? APAR_SLOT_SECOND
                                                                         : APAR_SLOT_FIRST));
    assign adc_free    = (ack_sync_reg == adc_req_reg);

    // Sample word crosses by request and acknowledge toggles: the held word never
    // changes while the link side may copy it; a stopped link clock keeps the last word
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            adc_hold_reg <= 16'h0;
            adc_req_reg  <= 1'b0;
            ack_meta_reg <= 1'b0;
            ack_sync_reg <= 1'b0;
        end else if (clk_en_in) begin
            ack_meta_reg <= adc_ack_reg;
            ack_sync_reg <= ack_meta_reg;
            if (adc_free) begin
                adc_hold_reg <= adc_sample_in;
                adc_req_reg  <= !adc_req_reg;
            end
        end
    end

    always_ff @(posedge link_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            lrst_meta_reg <= 1'b0;
            lrst_reg      <= 1'b0;
            cfg_meta_reg  <= 8'h00;
            cfg_link_reg  <= 8'h00;
            req_meta_reg  <= 1'b0;
            req_sync_reg  <= 1'b0;
            adc_ack_reg   <= 1'b0;
            adc_link_reg  <= 16'h0;
        end else begin
            lrst_meta_reg <= 1'b1;
            lrst_reg      <= lrst_meta_reg;
            cfg_meta_reg  <= port_cfg_reg;
            cfg_link_reg  <= cfg_meta_reg;
            req_meta_reg  <= adc_req_reg;
            req_sync_reg  <= req_meta_reg;
            if (req_sync_reg != adc_ack_reg) begin
                adc_link_reg <= adc_hold_reg;
                adc_ack_reg  <= req_sync_reg;
            end
        end
    end

    always_ff @(posedge link_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            fs_d_reg              <= 1'b0;
            bit_cnt_reg           <= 5'h0;
            slot_reg              <= APAR_SLOT_IDLE;
            tx_shift_reg          <= 16'h0;
            rx_shift_reg          <= 16'h0;
            rx_toggle_reg         <= 1'b0;
            rx_word_reg           <= 16'h0;
            mfs_cnt_reg           <= 5'h0;
            serial_audio_out      <= 1'b0;
            serial_audio_oe_n_out <= 1'b1;
            frame_sync_out        <= 1'b0;
            frame_sync_oe_n_out   <= 1'b1;
        end else if (lrst_reg) begin
            fs_d_reg            <= fs_src;
            mfs_cnt_reg         <= mfs_cnt_reg + 5'h1;
            frame_sync_out      <= cfg_link_reg[`APAR_BIT_MASTER] && (mfs_cnt_reg == 5'h0);
            frame_sync_oe_n_out <= !cfg_link_reg[`APAR_BIT_MASTER];
            if (fs_rise) begin
                slot_reg     <= APAR_SLOT_FIRST;
                bit_cnt_reg  <= 5'h0;
                tx_shift_reg <= adc_link_reg;
            end else if (slot_reg != APAR_SLOT_IDLE) begin
                bit_cnt_reg  <= slot_last ? 5'h0 : bit_cnt_reg + 5'h1;
                tx_shift_reg <= slot_last ? adc_link_reg : {tx_shift_reg[14:0], 1'b0};
                case (slot_reg)
                    APAR_SLOT_FIRST:  slot_reg <= slot_last ? APAR_SLOT_SECOND : APAR_SLOT_FIRST;
                    APAR_SLOT_SECOND: slot_reg <= slot_last ? APAR_SLOT_IDLE : APAR_SLOT_SECOND;
                    default:          slot_reg <= APAR_SLOT_IDLE;
                endcase
            end
            if (rx_slot_hit) begin
                rx_shift_reg <= {rx_shift_reg[14:0], link_rx_data_in};
                if (slot_last) begin
                    rx_word_reg   <= {rx_shift_reg[14:0], link_rx_data_in};
                    rx_toggle_reg <= !rx_toggle_reg;
                end
            end
            serial_audio_out      <= tx_slot_en && tx_shift_reg[15];
            // Float all but enabled transmit slots when enabled, idle time included, else always driven
            serial_audio_oe_n_out <= cfg_link_reg[`APAR_BIT_FLOAT_EN] && !tx_slot_en;
        end
    end

    // ************************************************************
    // Received word back to the system clock
    // ************************************************************
    logic        rxt_meta_reg;
    logic        rxt_sync_reg;
    logic        rxt_d_reg;
    wire  logic  rx_event;
    assign rx_event = rxt_sync_reg ^ rxt_d_reg;

    // Word is stable for a whole slot after the toggle, so it is sampled safely
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            rxt_meta_reg         <= 1'b0;
            rxt_sync_reg         <= 1'b0;
            rxt_d_reg            <= 1'b0;
            dac_sample_out       <= 16'h0;
            dac_sample_valid_out <= 1'b0;
            rx_slot_seen_reg     <= 1'b0;
        end else if (clk_en_in) begin
            rxt_meta_reg         <= rx_toggle_reg;
            rxt_sync_reg         <= rxt_meta_reg;
            rxt_d_reg            <= rxt_sync_reg;
            dac_sample_valid_out <= rx_event || (loopback_out && adc_sample_in != dac_sample_out);
            if (loopback_out) begin
                dac_sample_out <= adc_sample_in;
            end else if (rx_event) begin
                dac_sample_out <= rx_word_reg;
            end
            if (rx_event) begin
                rx_slot_seen_reg <= 1'b1;
            end
        end
    end
endmodule // apar_regs

/* test/apar_host_model.sv */
// Host serial port model: gated bit clock, frame sync and serial data
`timescale 1ns/1ns
module apar_host_model (
    input  wire logic        start_in,
    input  wire logic        run_in,
    input  wire logic [15:0] word_in,
    input  wire logic        serial_audio_in,
    input  wire logic        serial_audio_oe_n_in,
    output logic             link_clk_out,
    output logic             frame_sync_out,
    output logic             rx_data_out,
    output logic             busy_out,
    output logic [7:0]       low_count_out,
    output logic [15:0]      sent_out
);
    logic [31:0] bits;
    // ****************************************
    // Bit clock and frame driver
    // ****************************************
    initial begin
        {link_clk_out, frame_sync_out, rx_data_out, busy_out} = 4'h0;
        low_count_out = 8'h00;
        sent_out = 16'h0000;
        #7;
        forever begin
            #15;
            // Clock stops low between frames unless free running is asked for
            if (run_in || busy_out || link_clk_out) link_clk_out = ~link_clk_out;
        end
    end
    always @(posedge start_in) begin
        busy_out = 1'h1;
        low_count_out <= 8'h00;
        bits = {word_in, ~word_in};
        // Lead-in edges let the port settings cross into the link domain
        repeat (4) @(posedge link_clk_out);
        frame_sync_out <= 1'h1;
        @(posedge link_clk_out);
        frame_sync_out <= 1'h0;
        for (int i = 0; i < 40; i++) begin
            // Past the frame the line is released, so show a changing level
            rx_data_out <= (i < 32) ? bits[31 - i] : ~rx_data_out;
            @(posedge link_clk_out);
            if (serial_audio_oe_n_in === 1'b0) begin
                low_count_out <= low_count_out + 8'h01;
                sent_out <= {sent_out[14:0], serial_audio_in};
            end
        end
        busy_out = 1'h0;
    end
endmodule // apar_host_model

/* test/apar_regs_asserts.sv */
// Port checks for the audio port register bank
`timescale 1ns/1ns
module apar_regs_asserts (
    input wire logic                 clk_in,
    input wire logic                 reset_n_in,
    input wire logic                 clk_en_in,
    input wire logic                 psel_in,
    input wire logic                 penable_in,
    input wire logic                 pwrite_in,
    input wire logic [7:0]           paddr_in,
    input wire logic [31:0]          pwdata_in,
    input wire logic                 pready_out,
    input wire logic                 pslverr_out,
    input wire logic [15:0]          adc_sample_in,
    input wire logic [15:0]          dac_sample_out,
    input wire logic                 dac_sample_valid_out,
    input wire logic                 link_clk_in,
    input wire logic                 frame_sync_out,
    input wire logic                 frame_sync_oe_n_out,
    input wire logic                 loopback_out,
    input wire logic                 master_role_out,
    input wire logic                 short_frame_sync_out,
    input wire logic [15:0]          activity_off_time_out,
    input wire apar_pkg::apar_byte_t activity_on_time_out,
    input wire apar_pkg::apar_byte_t adc_activity_reference_out,
    input wire apar_pkg::apar_byte_t dac_activity_reference_out
);
    import apar_pkg::*;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    // ****************************************
    // Register writes and port state
    // ****************************************
    // Write lands at the first access edge; the copy shows one edge later
    property wr_p(logic [7:0] a, logic [7:0] q);
        psel_in && penable_in && pwrite_in && !pready_out && clk_en_in && paddr_in == a
            |=> ##1 q == $past(pwdata_in[7:0], 2);
    endproperty
    off_low_a: assert property (wr_p(8'h2c, activity_off_time_out[7:0])) else $error("off low");
    off_high_a: assert property (wr_p(8'h30, activity_off_time_out[15:8])) else $error("off high");
    on_time_a: assert property (wr_p(8'h34, activity_on_time_out)) else $error("on time");
    adc_ref_a: assert property (wr_p(8'h38, adc_activity_reference_out)) else $error("adc ref");
    dac_ref_a: assert property (wr_p(8'h3c, dac_activity_reference_out)) else $error("dac ref");
    apb_answer_a: assert property (psel_in && penable_in && !pready_out && clk_en_in |=> pready_out ##1 !pready_out)
        else $error("apb answer late");
    loopback_copy_a: assert property ((loopback_out && clk_en_in && $stable(adc_sample_in))[*4]
        |-> dac_sample_out == adc_sample_in) else $error("loopback copy");
    master_long_a: assert property (master_role_out |-> !short_frame_sync_out) else $error("master short");
    sync_drive_a: assert property (@(posedge link_clk_in) frame_sync_out |-> !frame_sync_oe_n_out)
        else $error("sync pulse not driven");
    valid_pulse_a: assert property ($changed(dac_sample_out) |-> dac_sample_valid_out)
        else $error("dac change without valid");
    error_pair_a: assert property (pslverr_out |-> pready_out) else $error("error alone");
    cover property (loopback_out && pready_out);
    cover property (master_role_out && !frame_sync_oe_n_out);
    cover property (pslverr_out);
endmodule // apar_regs_asserts

/* test/testbench.sv */
// Self-checking bench for the audio port register bank
`timescale 1ns/1ns
module testbench;
    import apar_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} apar_row_s;
    localparam logic [15:0] W1 = 16'h1234;
    logic        clk_in, reset_n_in, clk_en_in, bit_clock_strap_in, psel_in, penable_in, pwrite_in, er;
    logic [7:0]  paddr_in;
    logic [31:0] pwdata_in, prdata_out, rd;
    logic        pready_out, pslverr_out, link_clk_in, frame_sync_in, link_rx_data_in, start, run, busy;
    logic [15:0] adc_sample_in, dac_sample_out, activity_off_time_out, sent;
    logic        dac_sample_valid_out, serial_audio_out, serial_audio_oe_n_out, frame_sync_out;
    logic        frame_sync_oe_n_out, loopback_out, master_role_out, short_frame_sync_out;
    apar_byte_t  activity_on_time_out, adc_activity_reference_out, dac_activity_reference_out, n_low;
    int          n_mismatch, tests_run, cycles, n;
    apar_row_s   rows [10] = '{'{8'h2c, 32'h5a, 32'h5a, 1'h0}, '{8'h30, 32'ha5, 32'ha5, 1'h0},
        '{8'h34, 32'hff, 32'hff, 1'h0}, '{8'h38, 32'h01, 32'h01, 1'h0}, '{8'h3c, 32'h80, 32'h80, 1'h0},
        '{8'h24, 32'hce, 32'hee, 1'h0}, '{8'h24, 32'h11, 32'h21, 1'h0}, '{8'h24, 32'h10, 32'h30, 1'h0},
        '{8'h14, 32'hff, 32'h00, 1'h1}, '{8'h25, 32'hff, 32'h00, 1'h1}};
    logic [7:0]  lcfg [4] = '{8'h0c, 8'h4a, 8'h08, 8'h0e};
    logic [7:0]  lcnt [4] = '{8'h10, 8'h10, 8'h00, 8'h20};
    apar_regs dut (.clk_in, .reset_n_in, .clk_en_in, .bit_clock_strap_in, .psel_in, .penable_in,
        .pwrite_in, .paddr_in, .pwdata_in, .pready_out, .pslverr_out, .prdata_out, .link_clk_in,
        .frame_sync_in, .link_rx_data_in, .adc_sample_in, .dac_sample_out, .dac_sample_valid_out,
        .serial_audio_out, .serial_audio_oe_n_out, .frame_sync_out, .frame_sync_oe_n_out, .loopback_out,
        .master_role_out, .short_frame_sync_out, .activity_off_time_out, .activity_on_time_out,
        .adc_activity_reference_out, .dac_activity_reference_out);
    apar_host_model host (.start_in(start), .run_in(run), .word_in(W1), .serial_audio_in(serial_audio_out),
        .serial_audio_oe_n_in(serial_audio_oe_n_out), .link_clk_out(link_clk_in), .frame_sync_out(frame_sync_in),
        .rx_data_out(link_rx_data_in), .busy_out(busy), .low_count_out(n_low), .sent_out(sent));
    // ****************************************
    // Bus, compare and report tasks
    // ****************************************
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel_in <= 1'h1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'h1;
        // No wait count is assumed: only the bench timeout ends a stuck transfer
        do begin
            @(posedge clk_in);
        end while (pready_out !== 1'b1);
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 1'h0;
        penable_in <= 1'h0;
        @(posedge clk_in);
    endtask
    task automatic reset_dut(input logic strap);
        reset_n_in <= 1'h0;
        bit_clock_strap_in <= strap;
        repeat (8) @(posedge clk_in);
        reset_n_in <= 1'h1;
        repeat (8) @(posedge clk_in);
    endtask
    task automatic frame(input logic [7:0] cfg);
        apb(1'h1, 8'h24, {24'h0, cfg});
        start <= 1'h1;
        @(posedge clk_in);
        start <= 1'h0;
        while (busy !== 1'b0) begin
            @(posedge clk_in);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ****************************************
    // Stimulus
    // ****************************************
    always #20 clk_in = ~clk_in;
    // A full run takes about 430 cycles
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            summarize();
        end
    end
    initial begin
        {clk_in, clk_en_in, psel_in, penable_in, pwrite_in, start, run} = 7'h20;
        paddr_in = 8'h00;
        pwdata_in = 32'h0;
        adc_sample_in = 16'hc3a5;
        reset_dut(1'h0);
        for (int i = 0; i < 6; i++) begin
            apb(1'h0, rows[i].a, 32'h0);
            check("reset value", rd, (i == 5) ? 32'h25 : 32'h0);
        end
        check("short framing", {master_role_out, short_frame_sync_out}, 32'h1);
        $display("test reset done");
        foreach (rows[i]) begin
            apb(1'h1, rows[i].a, rows[i].d);
            check("write error", er, rows[i].e);
            apb(1'h0, rows[i].a, 32'h0);
            check("read back", {er, rd[30:0]}, {rows[i].e, rows[i].q[30:0]});
        end
        check("copies", {activity_off_time_out, activity_on_time_out, adc_activity_reference_out}, 32'ha55aff01);
        check("dac reference", dac_activity_reference_out, 32'h80);
        check("master role", {master_role_out, short_frame_sync_out}, 32'h2);
        $display("test registers done");
        run <= 1'h1;
        n = 0;
        repeat (80) begin
            @(posedge link_clk_in);
            if (frame_sync_out === 1'b1 && frame_sync_oe_n_out === 1'b0) n++;
        end
        @(posedge clk_in);
        run <= 1'h0;
        check("master framing", n, 32'h3);
        for (int i = 0; i < 4; i++) begin
            frame(lcfg[i]);
            check("driven slots", n_low, lcnt[i]);
            if (lcnt[i] == 8'h10) check("sent sample", sent, adc_sample_in);
            check("received", dac_sample_out, lcfg[i][6] ? 16'hedcb : W1);
        end
        frame(8'h04);
        check("continuous drive", n_low, 8'h28);
        apb(1'h0, 8'h40, 32'h0);
        check("word seen", rd, 32'h1);
        $display("test link done");
        apb(1'h1, 8'h24, 32'h84);
        repeat (4) @(posedge clk_in);
        check("loopback", dac_sample_out, 32'hc3a5);
        clk_en_in <= 1'h0;
        adc_sample_in <= 16'h0102;
        repeat (4) @(posedge clk_in);
        check("frozen", dac_sample_out, 32'hc3a5);
        clk_en_in <= 1'h1;
        repeat (4) @(posedge clk_in);
        check("loopback follows", dac_sample_out, 32'h0102);
        apb(1'h1, 8'h24, 32'h04);
        adc_sample_in <= 16'h0304;
        repeat (4) @(posedge clk_in);
        check("normal mode", dac_sample_out, 32'h0102);
        $display("test loopback done");
        reset_dut(1'h1);
        apb(1'h0, 8'h24, 32'h0);
        check("strap high", rd, 32'h24);
        check("strap framing", short_frame_sync_out, 32'h0);
        $display("test second reset done");
        summarize();
    end
endmodule // testbench
bind apar_regs apar_regs_asserts chk (.clk_in, .reset_n_in, .clk_en_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .pready_out, .pslverr_out, .adc_sample_in, .dac_sample_out, .dac_sample_valid_out,
    .link_clk_in, .frame_sync_out, .frame_sync_oe_n_out,
    .loopback_out, .master_role_out, .short_frame_sync_out, .activity_off_time_out, .activity_on_time_out,
    .adc_activity_reference_out, .dac_activity_reference_out);
